// File: rtl/tuner_cfg.svh
// constants for the tuner power and reset control block
// Overview of operation
// R1: power-down bit stops all analog except oscillator
// R2: serial interface keeps working in software power-down
// R3: sleep high adds oscillator stop: hardware power-down
// R4: sleep low means normal operation
// R5: bypass stays on if enabled before sleep
// R6: serial interface ignores bus while sleeping
// R7: reinit bit restores every register default
// R8: reinit bit clears itself, reads zero
// R9: reinit resets interface, write is not acknowledged
// R10: switch port off when zero, sinking when one
// R11: enabled bypass stays on in any power-down
// R12: registers load defaults at power-on
// R13: reinit fires only after complete data byte
`ifndef TUNER_CFG_SVH
`define TUNER_CFG_SVH

// device address value is arbitrary
`define DEV_ADDR_DEFAULT    7'h4b
`define REG_COUNT           16
`define REG_RFCTL_IDX       4'h4
`define REG_GENERAL_IDX     4'hf
`define REG_PLL0_IDX        4'h0
`define REG_BB7_IDX         4'h7
`define REG_LO8_IDX         4'h8
`define LOCK_FLAG_BIT       7
`define PASSTHROUGH_EN_POS  1
`define POWERDOWN_POS       7
`define REINIT_POS          6
`define SWITCH_PORT_POS     5

`define REG0_DEFAULT        8'h00
`define REG1_DEFAULT        8'h00
`define REG2_DEFAULT        8'h00
`define REG3_DEFAULT        8'h40
`define REG4_DEFAULT        8'h6e
`define REG5_DEFAULT        8'h3c
`define REG6_DEFAULT        8'h08
`define REG7_DEFAULT        8'h38
`define REG8_DEFAULT        8'h20
`define REG9_DEFAULT        8'ha2
`define REGA_DEFAULT        8'hf1
`define REGB_DEFAULT        8'h38
`define REGC_DEFAULT        8'hd0
`define REGD_DEFAULT        8'h10
`define REGE_DEFAULT        8'h30
`define REGF_DEFAULT        8'h80

// writable bits; the rest read back as status or zero
`define REG0_WMASK          8'h7f
`define REG1_WMASK          8'hff
`define REG2_WMASK          8'hff
`define REG3_WMASK          8'h7f
`define REG4_WMASK          8'h7f
`define REG5_WMASK          8'hff
`define REG6_WMASK          8'hff
`define REG7_WMASK          8'h7f
`define REG8_WMASK          8'h7f
`define REG9_WMASK          8'hff
`define REGA_WMASK          8'hff
`define REGB_WMASK          8'h3f
`define REGC_WMASK          8'hff
`define REGD_WMASK          8'h1f
`define REGE_WMASK          8'h3f
`define REGF_WMASK          8'hb0

`endif

// File: rtl/tuner_pkg.sv
// types for the tuner power and reset control block
package tuner_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_SUB,
    ST_ACK_SUB,
    ST_WR,
    ST_ACK_WR,
    ST_RD,
    ST_ACK_RD
  } serial_state_t;

  typedef struct packed {
    logic analog_off;
    logic xtal_off;
    logic passthrough_on;
  } power_ctl_t;

  typedef struct packed {
    logic pll_lock;
    logic bb_lock;
    logic full_lock;
  } lock_flags_t;

endpackage

// File: rtl/tuner_power_reset_control.sv
// serial register slave with power-down, reinit and switch port control
`timescale 1ns/10ps
`include "tuner_cfg.svh"
module tuner_power_reset_control #(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    scl,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  input  wire logic                    sleep,
  input  wire tuner_pkg::lock_flags_t  lock_flags,
  output logic                         switch_port_output,
  output logic                         switch_port_oe,
  output tuner_pkg::power_ctl_t        power_ctl
);

  localparam logic [7:0] DEFAULTS [`REG_COUNT] = '{
    `REG0_DEFAULT, `REG1_DEFAULT, `REG2_DEFAULT, `REG3_DEFAULT,
    `REG4_DEFAULT, `REG5_DEFAULT, `REG6_DEFAULT, `REG7_DEFAULT,
    `REG8_DEFAULT, `REG9_DEFAULT, `REGA_DEFAULT, `REGB_DEFAULT,
    `REGC_DEFAULT, `REGD_DEFAULT, `REGE_DEFAULT, `REGF_DEFAULT};
  localparam logic [7:0] WMASKS [`REG_COUNT] = '{
    `REG0_WMASK, `REG1_WMASK, `REG2_WMASK, `REG3_WMASK,
    `REG4_WMASK, `REG5_WMASK, `REG6_WMASK, `REG7_WMASK,
    `REG8_WMASK, `REG9_WMASK, `REGA_WMASK, `REGB_WMASK,
    `REGC_WMASK, `REGD_WMASK, `REGE_WMASK, `REGF_WMASK};

  // bus line sampling and edge detection
  logic                      scl_reg;
  logic                      sda_reg;
  logic                      scl_prev_reg;
  logic                      sda_prev_reg;
  logic                      scl_next;
  logic                      sda_next;
  logic                      scl_prev_next;
  logic                      sda_prev_next;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      bus_start;
  logic                      bus_stop;

  // serial engine state
  tuner_pkg::serial_state_t  state_reg;
  tuner_pkg::serial_state_t  state_next;
  logic [3:0]                cnt_reg;
  logic [3:0]                cnt_next;
  logic [7:0]                shift_reg;
  logic [7:0]                shift_next;
  logic [7:0]                tx_reg;
  logic [7:0]                tx_next;
  logic [3:0]                ptr_reg;
  logic [3:0]                ptr_next;
  logic                      sda_oe_reg;
  logic                      sda_oe_next;

  // register file
  logic [7:0]                regs_reg  [`REG_COUNT];
  logic [7:0]                regs_next [`REG_COUNT];
  logic                      wr_en;
  logic [3:0]                wr_idx;
  logic [7:0]                wr_data;
  logic                      soft_reinit;
  logic [7:0]                rd_byte;

  // outputs
  tuner_pkg::power_ctl_t     power_reg;
  tuner_pkg::power_ctl_t     power_next;
  logic                      port_oe_reg;
  logic                      port_oe_next;
  logic                      bypass_hold_reg;
  logic                      bypass_hold_next;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_reg      <= scl_next;
      sda_reg      <= sda_next;
      scl_prev_reg <= scl_prev_next;
      sda_prev_reg <= sda_prev_next;
    end
  end

  // one sample flop plus one history flop per bus line
  always_comb begin
    scl_next      = scl;
    sda_next      = sda_in;
    scl_prev_next = scl_reg;
    sda_prev_next = sda_reg;
  end

  always_comb begin
    scl_rise  = scl_reg & ~scl_prev_reg;
    scl_fall  = ~scl_reg & scl_prev_reg;
    bus_start = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
    bus_stop  = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
  end

  // read value: stored bits plus live lock flags
  always_comb begin
    rd_byte = regs_reg[ptr_reg] & WMASKS[ptr_reg];
    if (ptr_reg == `REG_PLL0_IDX) begin
      rd_byte[`LOCK_FLAG_BIT] = lock_flags.pll_lock;
    end else if (ptr_reg == `REG_BB7_IDX) begin
      rd_byte[`LOCK_FLAG_BIT] = lock_flags.bb_lock;
    end else if (ptr_reg == `REG_LO8_IDX) begin
      rd_byte[`LOCK_FLAG_BIT] = lock_flags.full_lock;
    end
  end

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    shift_next  = shift_reg;
    tx_next     = tx_reg;
    ptr_next    = ptr_reg;
    sda_oe_next = sda_oe_reg;
    wr_en       = 1'b0;
    wr_idx      = ptr_reg;
    wr_data     = shift_reg;
    soft_reinit = 1'b0;
    if (sleep) begin
      // no answer to the bus while sleeping [R6]
      state_next  = tuner_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (bus_stop) begin
      state_next  = tuner_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (bus_start) begin
      state_next  = tuner_pkg::ST_ADDR;
      cnt_next    = 4'h0;
      sda_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        tuner_pkg::ST_IDLE: begin
          sda_oe_next = 1'b0;
        end
        tuner_pkg::ST_ADDR, tuner_pkg::ST_SUB, tuner_pkg::ST_WR: begin
          if (scl_rise && cnt_reg != 4'h8) begin
            shift_next = {shift_reg[6:0], sda_reg};
            cnt_next   = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            if (state_reg == tuner_pkg::ST_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                state_next  = tuner_pkg::ST_ACK_ADDR;
                sda_oe_next = 1'b1;
              end else begin
                state_next = tuner_pkg::ST_IDLE;
              end
            end else if (state_reg == tuner_pkg::ST_SUB) begin
              ptr_next    = shift_reg[3:0];
              state_next  = tuner_pkg::ST_ACK_SUB;
              sda_oe_next = 1'b1;
            end else begin
              // whole byte is in before it acts [R13] [R2]
              wr_en    = 1'b1;
              ptr_next = ptr_reg + 4'h1;
              if (ptr_reg == `REG_GENERAL_IDX && shift_reg[`REINIT_POS]) begin
                soft_reinit = 1'b1; // [R7] [R13]
                // engine restarts clean, as after power-on
                state_next  = tuner_pkg::ST_IDLE; // [R9]
                shift_next  = 8'h00; // [R9]
                tx_next     = 8'h00; // [R9]
                sda_oe_next = 1'b0; // [R9]
                ptr_next    = 4'h0;
              end else begin
                state_next  = tuner_pkg::ST_ACK_WR;
                sda_oe_next = 1'b1;
              end
            end
          end
        end
        tuner_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (shift_reg[0]) begin
              state_next  = tuner_pkg::ST_RD;
              tx_next     = rd_byte;
              ptr_next    = ptr_reg + 4'h1;
              sda_oe_next = ~rd_byte[7];
            end else begin
              state_next  = tuner_pkg::ST_SUB;
              sda_oe_next = 1'b0;
            end
          end
        end
        tuner_pkg::ST_ACK_SUB, tuner_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            state_next  = tuner_pkg::ST_WR;
            sda_oe_next = 1'b0;
          end
        end
        tuner_pkg::ST_RD: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h7) begin
              state_next  = tuner_pkg::ST_ACK_RD;
              cnt_next    = 4'h0;
              sda_oe_next = 1'b0;
            end else begin
              tx_next     = {tx_reg[6:0], 1'b0};
              cnt_next    = cnt_reg + 4'h1;
              sda_oe_next = ~tx_reg[6];
            end
          end
        end
        tuner_pkg::ST_ACK_RD: begin
          if (scl_rise && sda_reg) begin
            state_next = tuner_pkg::ST_IDLE;
          end else if (scl_fall) begin
            state_next  = tuner_pkg::ST_RD;
            tx_next     = rd_byte;
            ptr_next    = ptr_reg + 4'h1;
            sda_oe_next = ~rd_byte[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg  <= tuner_pkg::ST_IDLE;
      cnt_reg    <= 4'h0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      ptr_reg    <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      tx_reg     <= tx_next;
      ptr_reg    <= ptr_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi++) begin : g_reg
      always_comb begin
        regs_next[gi] = regs_reg[gi];
        if (soft_reinit) begin
          regs_next[gi] = DEFAULTS[gi]; // [R7] [R8]
        end else if (wr_en && wr_idx == 4'(gi)) begin
          regs_next[gi] = (regs_reg[gi] & ~WMASKS[gi]) | (wr_data & WMASKS[gi]);
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          regs_reg[gi] <= DEFAULTS[gi]; // [R12]
        end else begin
          regs_reg[gi] <= regs_next[gi];
        end
      end
    end
  endgenerate

  // bypass enable as last written while awake; frozen while asleep
  // so the output keeps what was programmed before sleep [R5]
  always_comb begin
    bypass_hold_next = bypass_hold_reg;
    if (!sleep) begin
      bypass_hold_next = regs_next[`REG_RFCTL_IDX][`PASSTHROUGH_EN_POS];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bypass_hold_reg <= DEFAULTS[`REG_RFCTL_IDX][`PASSTHROUGH_EN_POS];
    end else begin
      bypass_hold_reg <= bypass_hold_next;
    end
  end

  always_comb begin
    power_next.analog_off     = regs_reg[`REG_GENERAL_IDX][`POWERDOWN_POS] | sleep; // [R1] [R3] [R4]
    power_next.xtal_off       = sleep; // [R3] [R4]
    // on in any power-down as long as the enable is set [R5] [R11]
    power_next.passthrough_on = bypass_hold_reg;
    port_oe_next              = regs_reg[`REG_GENERAL_IDX][`SWITCH_PORT_POS]; // [R10]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_reg   <= '0;
      port_oe_reg <= 1'b0;
    end else begin
      power_reg   <= power_next;
      port_oe_reg <= port_oe_next;
    end
  end

  assign sda_out            = 1'b0;
  assign sda_oe             = sda_oe_reg;
  assign switch_port_output = 1'b0;
  assign switch_port_oe     = port_oe_reg;
  assign power_ctl          = power_reg;

endmodule

// File: dv/tuner_power_reset_control_checker.sv
// assertion checker for the tuner power and reset control block
`timescale 1ns/10ps
module tuner_power_reset_control_checker (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   scl,
  input wire logic                   sda_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe,
  input wire logic                   sleep,
  input wire tuner_pkg::lock_flags_t lock_flags,
  input wire logic                   switch_port_output,
  input wire logic                   switch_port_oe,
  input wire tuner_pkg::power_ctl_t  power_ctl
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_xtal; $past(rst_n) |-> power_ctl.xtal_off == $past(sleep); endproperty
  a_xtal: assert property (p_xtal)
    else $error("oscillator power-down not tracking sleep");
  property p_analog; $past(rst_n) && $past(sleep) |-> power_ctl.analog_off; endproperty
  a_analog: assert property (p_analog)
    else $error("analog not powered down in sleep");
  property p_wake; $fell(power_ctl.analog_off) |-> !$past(sleep); endproperty
  a_wake: assert property (p_wake)
    else $error("analog woke while sleep high");
  property p_quiet; sleep [*3] |-> !sda_oe; endproperty
  a_quiet: assert property (p_quiet)
    else $error("data line driven while sleeping");
  property p_keep; $past(rst_n) && sleep && $past(sleep) |-> $stable(power_ctl.passthrough_on); endproperty
  a_keep: assert property (p_keep)
    else $error("bypass changed while sleeping");
  property p_dflt; $rose(rst_n) |=> power_ctl.analog_off && power_ctl.passthrough_on && !switch_port_oe; endproperty
  a_dflt: assert property (p_dflt)
    else $error("wrong state after reset");
  property p_sink; switch_port_output == 1'b0; endproperty
  a_sink: assert property (p_sink)
    else $error("port output not a sink");
  property p_sda_low; sda_out == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data line output not a pull-down");
  property p_rise; $rose(switch_port_oe) |-> !scl && !$past(scl, 2); endproperty
  a_rise: assert property (p_rise)
    else $error("port changed before byte end");
endmodule
bind tuner_power_reset_control tuner_power_reset_control_checker i_chk (.clk, .rst_n, .scl,
  .sda_in, .sda_out, .sda_oe, .sleep, .lock_flags, .switch_port_output, .switch_port_oe,
  .power_ctl);

// File: dv/bus_host.sv
// serial bus host model: drives the clock and pulls the data line low
`timescale 1ns/10ps
module bus_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // nine bits, the last one being the acknowledge slot
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_low = !d[i];
      half();
      scl = 1'b1;
      half();
      q[i] = sda;
      scl = 1'b0;
    end
  endtask
endmodule

// File: dv/tuner_power_reset_control_tb.sv
// self-checking bench for the tuner power and reset control block
`timescale 1ns/10ps
`include "tuner_cfg.svh"
module tuner_power_reset_control_tb;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   sleep = 1'b0;
  logic                   scl;
  logic                   sda_low;
  logic                   sda_out;
  logic                   sda_oe;
  logic                   port_val;
  logic                   port_oe;
  tuner_pkg::lock_flags_t lf = '0;
  tuner_pkg::power_ctl_t  pc;
  wire logic              sda = !(sda_low || sda_oe);
  logic [7:0]             exp_q[$];
  logic [7:0]             got;
  logic [7:0]             r;
  string                  gname;
  event                   seen;
  int                     n_fail = 0;
  int                     n_compared = 0;
  logic [7:0]             def [16] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h6e, 8'h3c, 8'h08,
    8'h38, 8'h20, 8'ha2, 8'hf1, 8'h38, 8'hd0, 8'h10, 8'h30, 8'h80};
  always #5 clk = ~clk;
  bus_host i_bus_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  tuner_power_reset_control i_tuner_power_reset_control (.clk(clk), .rst_n(rst_n),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .sleep(sleep),
    .lock_flags(lf), .switch_port_output(port_val), .switch_port_oe(port_oe),
    .power_ctl(pc));
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(seen) check(gname, exp_q.pop_front(), got);
  task automatic note(input string nm, input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    got = g;
    gname = nm;
    ->seen;
    @(negedge clk);
  endtask
  task automatic sel(input logic [3:0] a);
    logic [8:0] q;
    i_bus_host.start();
    i_bus_host.xfer({`DEV_ADDR_DEFAULT, 2'b01}, q);
    i_bus_host.xfer({4'h0, a, 1'b1}, q);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic ak);
    logic [8:0] q;
    sel(a);
    i_bus_host.xfer({d, 1'b1}, q);
    note("ack", {7'h0, ak}, {7'h0, !q[0]});
    i_bus_host.stop();
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [8:0] q;
    sel(a);
    i_bus_host.start();
    i_bus_host.xfer({`DEV_ADDR_DEFAULT, 2'b11}, q);
    i_bus_host.xfer(9'h1ff, q);
    note("data", e, q[8:1]);
    i_bus_host.stop();
  endtask
  task automatic report_and_stop();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #600_000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    r = $urandom(32'hcb27_e16c);
    lf = 3'($urandom);
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    note("pwr", 8'h05, {5'h0, pc});
    for (int i = 0; i < 16; i++) begin
      r = def[i];
      if (i == 0) r[7] = lf.pll_lock;
      if (i == 7) r[7] = lf.bb_lock;
      if (i == 8) r[7] = lf.full_lock;
      rd(4'(i), r);
    end
    r = 8'($urandom) | 8'h01;
    wr(4'h1, r, 1'b1);
    rd(4'h1, r);
    wr(4'hf, 8'h20, 1'b1);
    note("port", 8'h01, {7'h0, port_oe});
    note("pwr", 8'h01, {5'h0, pc});
    rd(4'hf, 8'h20);
    wr(4'hf, 8'h60, 1'b0);
    rd(4'hf, 8'h80);
    rd(4'h1, 8'h00);
    note("port", 8'h00, {7'h0, port_oe});
    for (int i = 0; i < 2; i++) begin
      wr(4'h4, 8'h6c | 8'(i << 1), 1'b1);
      wr(4'hf, 8'h00, 1'b1);
      sleep = 1'b1;
      repeat (2) @(negedge clk);
      note("pwr", 8'h06 | 8'(i), {5'h0, pc});
      wr(4'h1, r, 1'b0);
      sleep = 1'b0;
      repeat (2) @(negedge clk);
      note("pwr", 8'(i), {5'h0, pc});
      rd(4'h1, 8'h00);
    end
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(4'hf, 8'h80);
    report_and_stop();
  end
endmodule
